// ### sep_master.sv
// ssi master model: makes clock bursts and samples the data line
`default_nettype none
module sep_master #(
  parameter int HALF_NS = 40
) (
  // ssi link
  output logic sclk,
  input wire logic sdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock stands high outside bursts
  initial begin
    sclk = 1'b1;
  end
  // one burst of n clocks; each bit sampled late in the high phase
  // an 80 ns period leaves the port two system clocks per clock level
  task automatic read(input int n, output logic [31:0] bits);
    bits = '0;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      #(HALF_NS);
      sclk = 1'b1;
      #(HALF_NS);
      bits = {bits[30:0], sdata};
    end
  endtask : read
endmodule : sep_master
`default_nettype wire

// ### sep_pkg.sv
// package: constants, field layouts and carrier types of the ssi encoder port
`default_nettype none
package sep_pkg;
  // clock rate and link timing
  localparam int CLK_MHZ = 50;
  localparam int TEND_US = 10;
  localparam int MONO_US = 20;
  localparam int TEND_CYC = (TEND_US * CLK_MHZ < 1) ? 1 : TEND_US * CLK_MHZ;
  localparam int MONO_CYC = (MONO_US * CLK_MHZ < 1) ? 1 : MONO_US * CLK_MHZ;
  localparam int CNT_W = 11;
  // frame layout
  localparam int TURN_W = 12;
  localparam int ANGLE_W_MIN = 12;
  localparam int ANGLE_W_MAX = 14;
  localparam int FRAME_W = 32;
  localparam int LEN_W = 5;
  localparam logic [4:0] OPT_POS0 = 5'h07;
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FRAME = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  // control fields and reset values
  localparam int CTRL_WSEL_LSB = 0;
  localparam int CTRL_ALARM_BIT = 2;
  localparam int CTRL_PARITY_BIT = 3;
  localparam logic [1:0] WSEL_RESET = 2'h0;
  localparam logic [1:0] WSEL_MAX = 2'h2;
  // status fields
  localparam int ST_LINE_LSB = 0;
  localparam int ST_DIR_BIT = 2;
  localparam int ST_FAULT_LSB = 4;
  localparam int ST_LEN_LSB = 8;
  // line state of the data output
  typedef enum logic [1:0] {
    SEP_IDLE = 2'b00,
    SEP_BURST = 2'b01,
    SEP_HOLD = 2'b10
  } sep_line_t;
  // one snapshot: bits left aligned, msb sent first
  typedef struct packed {
    logic [FRAME_W-1:0] bits;
    logic [LEN_W-1:0] len;
  } sep_frame_t;
  // fault inputs feeding the alarm bit
  typedef struct packed {
    logic over_temp;
    logic under_temp;
    logic disc_break;
    logic led_fault;
  } sep_faults_t;
  // software controls
  typedef struct packed {
    logic parity_en;
    logic alarm_en;
    logic [1:0] wsel;
  } sep_ctrl_t;
endpackage : sep_pkg
`default_nettype wire

// ### sep_port.sv
// ssi slave port of a multiturn absolute encoder with apb control
`default_nettype none
module sep_port #(
  parameter int ADDR_W = 8
) (
  // system
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // position source, same clock
  input wire logic [sep_pkg::TURN_W-1:0] turn_count_bits,
  input wire logic [sep_pkg::ANGLE_W_MAX-1:0] angle_bits,
  // pins
  input wire logic dir_pin,
  input wire sep_pkg::sep_faults_t fault_pins,
  // ssi link
  input wire logic sclk,
  output logic sdata
);
  import sep_pkg::*;

  // elaboration check
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("sep_port: ADDR_W must lie in 8..32");
  end

  // pin synchronisers
  logic [1:0] dir_sync;
  sep_faults_t flt_s1;
  sep_faults_t flt_s2;
  logic [2:0] sclk_sync;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dir_sync <= 2'h3;
      flt_s1 <= '0;
      flt_s2 <= '0;
      sclk_sync <= 3'h7;
    end else begin
      dir_sync <= {dir_sync[0], dir_pin};
      flt_s1 <= fault_pins;
      flt_s2 <= flt_s1;
      sclk_sync <= {sclk_sync[1:0], sclk};
    end
  end

  logic dir_up;
  logic sclk_edge;
  logic sclk_fall;
  assign dir_up = dir_sync[1];
  assign sclk_edge = sclk_sync[1] ^ sclk_sync[2];
  assign sclk_fall = sclk_sync[2] & ~sclk_sync[1];

  // control register
  sep_ctrl_t ctrl;
  logic wr_ctrl;
  logic [1:0] wsel_in;
  assign wr_ctrl = psel & penable & pwrite & (paddr[7:0] == OFS_CTRL) & (paddr[ADDR_W-1:2] < 30'(4));
  assign wsel_in = pwdata[CTRL_WSEL_LSB +: 2];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= '{parity_en: 1'b0, alarm_en: 1'b0, wsel: WSEL_RESET};
    end else if (wr_ctrl) begin
      ctrl.wsel <= (wsel_in > WSEL_MAX) ? WSEL_MAX : wsel_in;
      ctrl.alarm_en <= pwdata[CTRL_ALARM_BIT];
      ctrl.parity_en <= pwdata[CTRL_PARITY_BIT];
    end
  end

  // frame builder from the live position
  sep_frame_t stage;
  logic [TURN_W-1:0] turn_v;
  logic [ANGLE_W_MAX-1:0] amask;
  logic [ANGLE_W_MAX-1:0] ang_v;
  logic [ANGLE_W_MAX-1:0] ang_al;
  logic alarm;
  logic par;
  always_comb begin
    turn_v = dir_up ? turn_count_bits : ~turn_count_bits;
    case (ctrl.wsel)
      2'h0: amask = 14'h0fff;
      2'h1: amask = 14'h1fff;
      default: amask = 14'h3fff;
    endcase
    ang_v = (dir_up ? angle_bits : ~angle_bits) & amask;
    ang_al = ang_v << (WSEL_MAX - ctrl.wsel);
    alarm = |flt_s2;
    par = ^{turn_v, ang_v} ^ (ctrl.alarm_en & alarm);
    stage.bits = {turn_v, ang_al, 6'h00};
    stage.bits[OPT_POS0 - {3'h0, ctrl.wsel}] = ctrl.alarm_en ? alarm : (ctrl.parity_en & par);
    stage.bits[OPT_POS0 - 5'h01 - {3'h0, ctrl.wsel}] = ctrl.alarm_en & ctrl.parity_en & par;
    stage.len = LEN_W'(TURN_W + ANGLE_W_MIN + 1) + {3'h0, ctrl.wsel}
      + {4'h0, ctrl.alarm_en} + {4'h0, ctrl.parity_en};
  end

  // line state machine and window counter
  sep_line_t line;
  logic [CNT_W-1:0] cnt;
  logic [15:0] burst_cnt;
  logic [15:0] resend_cnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line <= SEP_IDLE;
      cnt <= '0;
      burst_cnt <= '0;
      resend_cnt <= '0;
    end else begin
      case (line)
        SEP_IDLE: begin
          cnt <= '0;
          if (sclk_fall) begin
            line <= SEP_BURST;
            burst_cnt <= burst_cnt + 16'h0001;
          end
        end
        SEP_BURST: begin
          if (sclk_edge) begin
            cnt <= '0;
          end else if (cnt == CNT_W'(TEND_CYC - 1)) begin
            line <= SEP_HOLD;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        SEP_HOLD: begin
          if (sclk_fall) begin
            line <= SEP_BURST;
            cnt <= '0;
            resend_cnt <= resend_cnt + 16'h0001;
          end else if (cnt == CNT_W'(MONO_CYC - 1)) begin
            line <= SEP_IDLE;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: begin
          line <= SEP_IDLE;
          cnt <= '0;
        end
      endcase
    end
  end

  // double buffer: written only while idle, frozen during burst and window
  sep_frame_t snap [2];
  logic pub_sel;
  logic wph;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      snap[0] <= '0;
      snap[1] <= '0;
      pub_sel <= 1'b0;
      wph <= 1'b0;
    end else if (line == SEP_IDLE) begin
      if (!wph) begin
        snap[~pub_sel] <= stage;
      end else begin
        pub_sel <= ~pub_sel;
      end
      wph <= ~wph;
    end
  end

  // idle flag for the link domain, registered so it cannot glitch
  // when the line state hops between burst and hold (two bits change)
  logic fresh;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fresh <= 1'b1;
    end else begin
      fresh <= (line == SEP_IDLE);
    end
  end

  // link domain: capture on falling edge, level stable at that edge
  // a burst inside the low window keeps the earlier capture, so the resend
  // carries exactly the frame that went out before
  logic quiet;
  logic quiet_q;
  sep_frame_t cap0;
  sep_frame_t cap1;
  logic cap_sel;
  assign quiet = (line != SEP_BURST);
  always_ff @(negedge sclk or negedge nrst) begin
    if (!nrst) begin
      quiet_q <= 1'b0;
      cap0 <= '0;
      cap1 <= '0;
      cap_sel <= 1'b0;
    end else begin
      quiet_q <= quiet;
      if (quiet && fresh) begin
        cap0 <= snap[0];
        cap1 <= snap[1];
        cap_sel <= pub_sel;
      end
    end
  end

  // link domain: shift one bit per rising edge, ring over the frame
  sep_frame_t act;
  logic [LEN_W-1:0] ptr;
  logic link_bit;
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      act <= '0;
      ptr <= '0;
      link_bit <= 1'b1;
    end else if (quiet_q) begin
      act <= cap_sel ? cap1 : cap0;
      link_bit <= cap_sel ? cap1.bits[FRAME_W-1] : cap0.bits[FRAME_W-1];
      ptr <= LEN_W'(1);
    end else begin
      link_bit <= act.bits[5'd31 - ptr];
      ptr <= (ptr == act.len - 1'b1) ? '0 : ptr + 1'b1;
    end
  end

  // data pin: shift bit in burst, low in window, high when idle
  assign sdata = (line == SEP_BURST) ? link_bit : (line == SEP_IDLE);

  // apb read path, registered in the setup phase
  logic setup;
  logic mapped;
  logic [31:0] rd_mux;
  assign setup = psel & ~penable;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:2] < 30'(4));
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr[7:0])
      OFS_CTRL: rd_mux = {28'h0, ctrl.parity_en, ctrl.alarm_en, ctrl.wsel};
      OFS_STATUS: begin
        rd_mux[ST_LINE_LSB +: 2] = line;
        rd_mux[ST_DIR_BIT] = dir_up;
        rd_mux[ST_FAULT_LSB +: 4] = flt_s2;
        rd_mux[ST_LEN_LSB +: LEN_W] = stage.len;
      end
      OFS_FRAME: rd_mux = snap[pub_sel].bits;
      OFS_COUNT: rd_mux = {resend_cnt, burst_cnt};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= (mapped && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= ~mapped;
    end
  end
  assign pready = psel & penable;

  // helper: length of each low window
  logic [CNT_W-1:0] hold_len;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_len <= '0;
    end else if (line == SEP_HOLD) begin
      hold_len <= hold_len + 1'b1;
    end else begin
      hold_len <= '0;
    end
  end

  // checks in the system clock domain
  idle_high_a: assert property (@(posedge clk) disable iff (!nrst)
    (line == SEP_IDLE) |-> sdata)
    else $error("line not high while idle");

  sequence burst_ends_s;
    (line == SEP_BURST) && !sclk_edge && (cnt == CNT_W'(TEND_CYC - 1));
  endsequence
  hold_low_a: assert property (@(posedge clk) disable iff (!nrst)
    burst_ends_s |=> (line == SEP_HOLD) && !sdata [*8])
    else $error("line not low after the transfer");

  window_len_a: assert property (@(posedge clk) disable iff (!nrst)
    (line == SEP_IDLE) && ($past(line) == SEP_HOLD) |-> ($past(hold_len) == CNT_W'(MONO_CYC - 1)))
    else $error("low window of wrong length");

  retrigger_a: assert property (@(posedge clk) disable iff (!nrst)
    (line == SEP_HOLD) && sclk_fall |=> (line == SEP_BURST) && (cnt == '0))
    else $error("burst in window not taken as resend");

  freeze_a: assert property (@(posedge clk) disable iff (!nrst)
    (line != SEP_IDLE) && ($past(line) != SEP_IDLE) |-> $stable(pub_sel) && $stable(snap[0]) && $stable(snap[1]))
    else $error("snapshot changed outside idle");

  parity_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl.parity_en |-> (^stage.bits == 1'b0))
    else $error("frame parity not even");

  alarm_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl.alarm_en |-> (stage.bits[OPT_POS0 - {3'h0, ctrl.wsel}] == (|flt_s2)))
    else $error("alarm bit does not follow faults");

  turn_first_a: assert property (@(posedge clk) disable iff (!nrst)
    stage.bits[FRAME_W-1 -: TURN_W] == (dir_up ? turn_count_bits : ~turn_count_bits))
    else $error("turn count not at frame head");

  length_a: assert property (@(posedge clk) disable iff (!nrst)
    stage.len == LEN_W'(25 + ctrl.wsel + ctrl.alarm_en + ctrl.parity_en))
    else $error("frame length wrong");

  // checks in the link clock domain
  ring_wrap_a: assert property (@(posedge sclk) disable iff (!nrst)
    !quiet_q && (ptr == act.len - 1'b1) |=> (ptr == '0))
    else $error("frame does not repeat after zero bit");

  msb_first_a: assert property (@(posedge sclk) disable iff (!nrst)
    quiet_q |=> (ptr == LEN_W'(1)) && (link_bit == act.bits[FRAME_W-1]))
    else $error("burst does not start at msb");

  // checks on the window and burst counters, the frame tail and the fresh flag
  sequence window_ends_s;
    (line == SEP_HOLD) && !sclk_fall && (cnt == CNT_W'(MONO_CYC - 1));
  endsequence
  window_exit_a: assert property (@(posedge clk) disable iff (!nrst)
    window_ends_s |=> (line == SEP_IDLE) && sdata)
    else $error("line not back high after the window");

  sequence edge_in_burst_s;
    (line == SEP_BURST) && sclk_edge;
  endsequence
  burst_restart_a: assert property (@(posedge clk) disable iff (!nrst)
    edge_in_burst_s |=> (line == SEP_BURST) && (cnt == '0))
    else $error("burst end counter not restarted by a clock edge");

  zero_tail_a: assert property (@(posedge clk) disable iff (!nrst)
    (stage.bits << (stage.len - 5'h01)) == 32'h0000_0000)
    else $error("frame does not end in a zero bit");

  fresh_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    (line == SEP_HOLD) |-> !fresh)
    else $error("window allows a fresh capture");

  // checks on the register bus
  slave_error_a: assert property (@(posedge clk) disable iff (!nrst)
    setup && !mapped |=> pslverr)
    else $error("unmapped address not refused");

  wsel_clamp_a: assert property (@(posedge clk) disable iff (!nrst)
    wr_ctrl && (wsel_in > WSEL_MAX) |=> (ctrl.wsel == WSEL_MAX))
    else $error("wide angle select not clamped");

endmodule : sep_port
`default_nettype wire

// ### sep_port_note_unused.sv
// intentionally empty design unit holder
`default_nettype none
`default_nettype wire

// ### ssi_multiturn_encoder_port_tb.sv
// self-checking bench of the ssi encoder port
`default_nettype none
module ssi_multiturn_encoder_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sep_pkg::*;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, dir_pin, sclk, sdata;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] turn;
  logic [13:0] angle;
  sep_faults_t faults;
  int errors, n_checks;
  logic [31:0] seed = 32'h0222;
  // device and far-side master
  sep_port u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .turn_count_bits(turn),
    .angle_bits(angle), .dir_pin(dir_pin), .fault_pins(faults), .sclk(sclk), .sdata(sdata));
  sep_master u_master (.sclk(sclk), .sdata(sdata));
  // 50 mhz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // lfsr random source
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  // expected frame, left aligned, and its length
  function automatic logic [31:0] frame_of(input logic [11:0] t, input logic [13:0] a, input logic [1:0] w,
      input logic al, input logic pe, input logic d, input logic [3:0] f, output int len);
    logic [31:0] acc;
    int wa;
    wa = 12 + int'(w);
    acc = {20'h0, d ? t : ~t};
    for (int i = wa - 1; i >= 0; i--) begin
      acc = {acc[30:0], d ? a[i] : ~a[i]};
    end
    len = 13 + wa;
    if (al) begin
      acc = {acc[30:0], |f};
      len++;
    end
    if (pe) begin
      acc = {acc[30:0], ^acc};
      len++;
    end
    acc = {acc[30:0], 1'b0};
    return acc << (32 - len);
  endfunction : frame_of
  // first n bits seen on the line, wrapping at the frame end
  function automatic logic [31:0] seen(input logic [31:0] fr, input int len, input int n);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < n; i++) begin
      r = {r[30:0], fr[31 - (i % len)]};
    end
    return r;
  endfunction : seen
  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
      output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // counts, verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  // watchdog against a hung run
  initial begin
    #1000000;
    errors++;
    summarize();
  end
  // main sequence
  initial begin
    logic [31:0] rd, fr, got, r;
    logic err, al, pe;
    logic [1:0] w;
    int len, n;
    errors = 0;
    n_checks = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    turn = '0;
    angle = '0;
    dir_pin = 1'b1;
    faults = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0, rd, err);
    chk(rd, 32'h0);
    apb(1'b1, 8'h10, 32'hffff_ffff, rd, err);
    chk({31'h0, err}, 32'h1);
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      w = (k == 3) ? 2'h3 : 2'(r % 3);
      al = (k == 7) | r[4];
      pe = (k == 7) | r[5];
      apb(1'b1, OFS_CTRL, {28'h0, pe, al, w}, rd, err);
      apb(1'b0, OFS_CTRL, 32'h0, rd, err);
      w = (w == 2'h3) ? WSEL_MAX : w;
      chk(rd, {28'h0, pe, al, w});
      r = rnd();
      turn <= r[11:0];
      angle <= r[25:12];
      dir_pin <= (k == 2) ? 1'b0 : r[26];
      faults <= sep_faults_t'(r[31:28]);
      repeat (6) @(posedge clk);
      fr = frame_of(turn, angle, w, al, pe, dir_pin, faults, len);
      apb(1'b0, OFS_STATUS, 32'h0, rd, err);
      chk({27'h0, rd[12:8]}, 32'(len));
      chk({30'h0, rd[1:0]}, 32'h0);
      chk({31'h0, rd[2]}, {31'h0, dir_pin});
      n = (k % 2) ? len + 3 : len;
      #3;
      u_master.read(n, got);
      chk(got, seen(fr, len, n));
      @(posedge clk);
      turn <= ~turn;
      angle <= ~angle;
      apb(1'b0, OFS_FRAME, 32'h0, rd, err);
      chk(rd, fr);
      #15010;
      chk({31'h0, sdata}, 32'h0);
      u_master.read(n, got);
      chk(got, seen(fr, len, n));
      apb(1'b0, OFS_COUNT, 32'h0, rd, err);
      chk(rd, {16'(k + 1), 16'(k + 1)});
      #40010;
      chk({31'h0, sdata}, 32'h1);
    end
    summarize();
  end
endmodule : ssi_multiturn_encoder_port_tb
`default_nettype wire
